// File: rtl/psw_pkg.sv
// package: status word layout, reset values, request codes and carriers
package psw_pkg;

    // ****************************************************************
    // status word layout
    // ****************************************************************
    localparam int          PSW_W          = 24;
    localparam int          EXT_LSB        = 16;
    localparam int          MODE_LSB       = 8;
    localparam int          CC_LSB         = 0;
    localparam int          CORE_PRIO_LSB  = 22;
    localparam int          ROUND_SEL_BIT  = 21;
    localparam int          FOREVER_BIT    = 16;
    localparam int          LOOP_BIT       = 15;
    localparam int          IMASK_LSB      = 8;
    localparam int          CC_SCALE_BIT   = 7;
    localparam int          CC_LIMIT_BIT   = 6;
    localparam logic [23:0] RSVD_MASK      = 24'h041000;
    localparam logic [23:0] PMOVE_MASK     = 24'h0000c0;
    localparam logic [23:0] EXT_MASK       = 24'hff0000;
    localparam logic [23:0] MODE_MASK      = 24'h00ff00;
    localparam logic [23:0] CC_MASK        = 24'h0000ff;
    localparam logic [7:0]  EXT_RESET      = 8'hc0;
    localparam logic [7:0]  MODE_RESET     = 8'h03;
    localparam logic [7:0]  CC_RESET       = 8'h00;
    localparam logic [1:0]  IMASK_ALL      = 2'h3;

    // ****************************************************************
    // arbitration
    // ****************************************************************
    localparam int          NSRC           = 4;
    localparam logic [1:0]  SRC_P          = 2'h0;
    localparam logic [1:0]  SRC_X          = 2'h1;
    localparam logic [1:0]  SRC_Y          = 2'h2;
    localparam logic [1:0]  SRC_DMA        = 2'h3;

    typedef enum logic [1:0] {
        SEL_DYNAMIC = 2'h0,
        SEL_CORE_LO = 2'h1,
        SEL_EQUAL   = 2'h2,
        SEL_CORE_HI = 2'h3
    } psw_prio_sel_t;

    typedef enum logic [1:0] {
        REL_EQUAL   = 2'h0,
        REL_CORE_HI = 2'h1,
        REL_CORE_LO = 2'h2
    } psw_prio_rel_t;

    // ****************************************************************
    // requests from the instruction sequencer
    // ****************************************************************
    typedef enum logic [3:0] {
        OP_NONE     = 4'h0,
        OP_ALU      = 4'h1,
        OP_PMOVE    = 4'h2,
        OP_IMM_AND  = 4'h3,
        OP_IMM_OR   = 4'h4,
        OP_MOVE     = 4'h5,
        OP_LOOP     = 4'h6,
        OP_FOREVER  = 4'h7,
        OP_CALL     = 4'h8,
        OP_EXCEPT   = 4'h9,
        OP_TRAP     = 4'ha,
        OP_LOOP_END = 4'hb,
        OP_BREAK    = 4'hc,
        OP_RTI      = 4'hd
    } psw_op_t;

    typedef enum logic [1:0] {
        TGT_CC   = 2'h0,
        TGT_MODE = 2'h1,
        TGT_PSW  = 2'h2
    } psw_tgt_t;

    typedef struct packed {
        psw_op_t     op;
        psw_tgt_t    tgt;
        logic [23:0] data;
    } psw_req_t;

endpackage : psw_pkg

// File: rtl/psw_top.sv
// status word: three sub-bytes, stacking, rounding select, bus arbitration
`timescale 1ns/1ps
// Behaviour
// - one 24-bit status word holds processor state
// - push whole word on loop, call, interrupt
// - bytes: extended 23-16, mode 15-8, cc 7-0
// - reset, exception, exit, return, trap change modes
// - status-word destinations also update extended byte
// - loops, and/or/move update mode byte
// - reset clears extended byte, core priority 11
// - reset sets interrupt masks, clears other mode
// - cc from alu, moves, logic, word writes
// - parallel move touches only bits 7,6
// - reset clears whole condition code byte
// - reserved bits 18 and 12 read zero
// - core priority compared with dma priority
// - higher priority side wins, other waits
// - equal priority: round robin p,x,y,dma
// - bit 21 picks convergent or two's-complement rounding
module psw_top (
    input  wire logic              clk_i,
    input  wire logic              rst_b_i,
    input  wire psw_pkg::psw_req_t req_i,
    input  wire logic [23:0]       pop_data_i,
    input  wire logic [1:0]        core_dma_prio_select_i,
    input  wire logic [1:0]        dma_prio_field_i,
    input  wire logic [2:0]        core_req_i,
    input  wire logic              dma_req_i,
    output logic [23:0]            psw_o,
    output logic                   round_select_o,
    output logic                   push_o,
    output logic [23:0]            push_data_o,
    output logic                   pop_o,
    output logic [3:0]             grant_o
);

    // ****************************************************************
    // status word update
    // ****************************************************************
    logic [23:0]       psw_reg;
    logic [23:0]       psw_next;
    logic [23:0]       psw_reset;
    logic [23:0]       write_mask;
    logic [23:0]       write_val;
    psw_pkg::psw_op_t  op;

    assign op        = req_i.op;
    assign psw_reset = {psw_pkg::EXT_RESET, psw_pkg::MODE_RESET, psw_pkg::CC_RESET};

    // byte lanes that an immediate or move may reach, by destination
    function automatic logic [23:0] tgt_mask(input psw_pkg::psw_tgt_t tgt);
        logic [23:0] m;
        m = 24'h000000;
        unique case (tgt)
            psw_pkg::TGT_CC:   m = psw_pkg::CC_MASK;
            psw_pkg::TGT_MODE: m = psw_pkg::MODE_MASK;
            psw_pkg::TGT_PSW:  m = psw_pkg::EXT_MASK | psw_pkg::MODE_MASK | psw_pkg::CC_MASK;
            default:           m = 24'h000000;
        endcase
        return m;
    endfunction : tgt_mask

    // work out which bits change and to what; one source per cycle
    always_comb begin
        write_mask = 24'h000000;
        write_val  = psw_reg;
        unique case (op)
            psw_pkg::OP_ALU: begin
                write_mask = psw_pkg::CC_MASK;
                write_val  = req_i.data;
            end
            psw_pkg::OP_PMOVE: begin
                write_mask = psw_pkg::PMOVE_MASK;
                write_val  = req_i.data;
            end
            psw_pkg::OP_IMM_AND: begin
                write_mask = tgt_mask(req_i.tgt);
                write_val  = psw_reg & req_i.data;
            end
            psw_pkg::OP_IMM_OR: begin
                write_mask = tgt_mask(req_i.tgt);
                write_val  = psw_reg | req_i.data;
            end
            psw_pkg::OP_MOVE: begin
                write_mask = tgt_mask(req_i.tgt);
                write_val  = req_i.data;
            end
            psw_pkg::OP_LOOP: begin
                write_mask = 24'h000000;
                write_mask[psw_pkg::LOOP_BIT] = 1'b1;
                write_val[psw_pkg::LOOP_BIT]  = 1'b1;
            end
            psw_pkg::OP_FOREVER: begin
                write_mask = 24'h000000;
                write_mask[psw_pkg::LOOP_BIT]    = 1'b1;
                write_mask[psw_pkg::FOREVER_BIT] = 1'b1;
                write_val[psw_pkg::LOOP_BIT]     = 1'b1;
                write_val[psw_pkg::FOREVER_BIT]  = 1'b1;
            end
            psw_pkg::OP_EXCEPT,
            psw_pkg::OP_TRAP: begin
                // exception entry sets the interrupt mask to the level given
                write_mask = 24'h000000;
                write_mask[psw_pkg::IMASK_LSB +: 2] = 2'h3;
                write_val[psw_pkg::IMASK_LSB +: 2]  = req_i.data[psw_pkg::IMASK_LSB +: 2];
            end
            psw_pkg::OP_LOOP_END,
            psw_pkg::OP_BREAK: begin
                // loop state comes back from the stack; flags stay
                write_mask = psw_pkg::EXT_MASK | psw_pkg::MODE_MASK;
                write_val  = pop_data_i;
            end
            psw_pkg::OP_RTI: begin
                write_mask = psw_pkg::EXT_MASK | psw_pkg::MODE_MASK | psw_pkg::CC_MASK;
                write_val  = pop_data_i;
            end
            default: begin
                write_mask = 24'h000000;
                write_val  = psw_reg;
            end
        endcase
    end

    // merge, then force reserved bits low whatever was written
    assign psw_next = ((psw_reg & ~write_mask) | (write_val & write_mask))
                      & ~psw_pkg::RSVD_MASK;

    // the status word itself
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            psw_reg <= psw_reset;
        end else begin
            psw_reg <= psw_next;
        end
    end

    assign psw_o          = psw_reg;
    assign round_select_o = psw_reg[psw_pkg::ROUND_SEL_BIT];

    // ****************************************************************
    // system stack traffic
    // ****************************************************************
    logic        push_reg;
    logic [23:0] push_data_reg;
    logic        push_req;

    // calls, long interrupts and loop starts save the word before it changes
    assign push_req = (op == psw_pkg::OP_CALL) || (op == psw_pkg::OP_EXCEPT)
                      || (op == psw_pkg::OP_LOOP) || (op == psw_pkg::OP_FOREVER);

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            push_reg      <= 1'b0;
            push_data_reg <= 24'h000000;
        end else begin
            push_reg      <= push_req;
            push_data_reg <= push_req ? psw_reg : push_data_reg;
        end
    end

    assign push_o      = push_reg;
    assign push_data_o = push_data_reg;
    // pop strobe tells the stack its top word was consumed this cycle
    assign pop_o = (op == psw_pkg::OP_LOOP_END) || (op == psw_pkg::OP_BREAK)
                   || (op == psw_pkg::OP_RTI);

    // ****************************************************************
    // external bus arbitration
    // ****************************************************************
    psw_pkg::psw_prio_rel_t rel;
    logic [1:0]             core_prio;
    logic [1:0]             rr_reg;
    logic [1:0]             rr_next;
    logic [3:0]             req_all;
    logic [3:0]             req_eligible;
    logic [3:0]             grant;
    logic                   core_any;

    assign core_prio = psw_reg[psw_pkg::CORE_PRIO_LSB +: 2];
    assign core_any  = |core_req_i;
    assign req_all   = {dma_req_i, core_req_i};

    // relation of core to dma under the mode select
    function automatic psw_pkg::psw_prio_rel_t prio_rel(input logic [1:0] sel,
                                                        input logic [1:0] cp,
                                                        input logic [1:0] dp);
        psw_pkg::psw_prio_rel_t r;
        r = psw_pkg::REL_EQUAL;
        unique case (psw_pkg::psw_prio_sel_t'(sel))
            psw_pkg::SEL_DYNAMIC: begin
                if (cp > dp) begin
                    r = psw_pkg::REL_CORE_HI;
                end else if (cp < dp) begin
                    r = psw_pkg::REL_CORE_LO;
                end else begin
                    r = psw_pkg::REL_EQUAL;
                end
            end
            psw_pkg::SEL_CORE_LO: r = psw_pkg::REL_CORE_LO;
            psw_pkg::SEL_EQUAL:   r = psw_pkg::REL_EQUAL;
            psw_pkg::SEL_CORE_HI: r = psw_pkg::REL_CORE_HI;
        endcase
        return r;
    endfunction : prio_rel

    assign rel = prio_rel(core_dma_prio_select_i, core_prio, dma_prio_field_i);

    // the losing side only gets a slot the winner leaves free
    always_comb begin
        unique case (rel)
            psw_pkg::REL_CORE_HI: req_eligible = core_any ? {1'b0, core_req_i} : req_all;
            psw_pkg::REL_CORE_LO: req_eligible = dma_req_i ? 4'h8 : req_all;
            default:              req_eligible = req_all;
        endcase
    end

    // first eligible source at or after the pointer; one grant per slot
    always_comb begin
        logic [1:0] idx;
        logic       found;
        idx     = 2'h0;
        found   = 1'b0;
        grant   = 4'h0;
        rr_next = rr_reg;
        for (int i = 0; i < psw_pkg::NSRC; i++) begin
            idx = rr_reg + 2'(i);
            if (!found && req_eligible[idx]) begin
                found      = 1'b1;
                grant[idx] = 1'b1;
                rr_next    = idx + 2'h1;
            end
        end
    end

    // pointer moves past the last winner so p, x, y, dma take turns
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            rr_reg <= psw_pkg::SRC_P;
        end else begin
            rr_reg <= rr_next;
        end
    end

    assign grant_o = grant;

    // ****************************************************************
    // checks
    // ****************************************************************
    chk_reset_value: assert property (
        @(posedge clk_i) !rst_b_i
            |=> psw_o == {psw_pkg::EXT_RESET, psw_pkg::MODE_RESET, psw_pkg::CC_RESET}
    ) else $error("status word wrong after reset");

    chk_reserved_zero: assert property (
        @(posedge clk_i) disable iff (!rst_b_i)
        (psw_o[18] == 1'b0) && (psw_o[12] == 1'b0)
    ) else $error("reserved status bit reads one");

    chk_push_saves_word: assert property (
        @(posedge clk_i) disable iff (!rst_b_i)
        (op == psw_pkg::OP_CALL) |=> push_o && (push_data_o == $past(psw_o))
    ) else $error("call did not push the status word");

    chk_pmove_only_sl: assert property (
        @(posedge clk_i) disable iff (!rst_b_i)
        (op == psw_pkg::OP_PMOVE) |=> (psw_o[23:8] == $past(psw_o[23:8]))
            && (psw_o[5:0] == $past(psw_o[5:0])) && (psw_o[7:6] == $past(req_i.data[7:6]))
    ) else $error("parallel move touched other flags");

    chk_alu_sets_cc: assert property (
        @(posedge clk_i) disable iff (!rst_b_i)
        (op == psw_pkg::OP_ALU) |=> (psw_o[7:0] == $past(req_i.data[7:0]))
            && (psw_o[23:8] == $past(psw_o[23:8]))
    ) else $error("alu result not in condition byte");

    chk_forever_flags: assert property (
        @(posedge clk_i) disable iff (!rst_b_i)
        (op == psw_pkg::OP_FOREVER) |=> psw_o[psw_pkg::FOREVER_BIT] && psw_o[psw_pkg::LOOP_BIT]
            && push_o && (push_data_o == $past(psw_o))
    ) else $error("forever loop flags not set");

    chk_rti_restores: assert property (
        @(posedge clk_i) disable iff (!rst_b_i)
        (op == psw_pkg::OP_RTI) |=> psw_o == ($past(pop_data_i) & 24'hfbefff)
    ) else $error("return did not restore the word");

    chk_core_hi_holds: assert property (
        @(posedge clk_i) disable iff (!rst_b_i)
        (core_dma_prio_select_i == 2'h3) && core_any |-> !grant_o[3] && ($countones(grant_o) == 1)
    ) else $error("dma granted over higher core");

    chk_core_lo_yields: assert property (
        @(posedge clk_i) disable iff (!rst_b_i)
        (core_dma_prio_select_i == 2'h1) && dma_req_i |-> grant_o == 4'h8
    ) else $error("core granted over higher dma");

    chk_round_robin: assert property (
        @(posedge clk_i) disable iff (!rst_b_i)
        (core_dma_prio_select_i == 2'h2) && grant_o[3] ##1
            ((core_dma_prio_select_i == 2'h2) && (req_all == 4'hf)) |-> grant_o == 4'h1
    ) else $error("round robin did not wrap to program");

    chk_round_select: assert property (
        @(posedge clk_i) disable iff (!rst_b_i)
        (op == psw_pkg::OP_MOVE) && (req_i.tgt == psw_pkg::TGT_PSW)
            |=> round_select_o == $past(req_i.data[psw_pkg::ROUND_SEL_BIT])
    ) else $error("rounding select does not follow the word");

    // loop start must stack the word as it was, then raise the loop flag
    chk_loop_pushes_word: assert property (
        @(posedge clk_i) disable iff (!rst_b_i)
        (op == psw_pkg::OP_LOOP) |=> push_o && psw_o[psw_pkg::LOOP_BIT]
            && (push_data_o == $past(psw_o))
    ) else $error("loop start did not push the status word");

    chk_except_mask_level: assert property (
        @(posedge clk_i) disable iff (!rst_b_i)
        (op == psw_pkg::OP_EXCEPT) || (op == psw_pkg::OP_TRAP)
            |=> psw_o[psw_pkg::IMASK_LSB +: 2] == $past(req_i.data[psw_pkg::IMASK_LSB +: 2])
    ) else $error("exception entry left the interrupt mask wrong");

    // a loop exit must not disturb the flags of the arithmetic that ran inside it
    chk_exit_keeps_cc: assert property (
        @(posedge clk_i) disable iff (!rst_b_i)
        (op == psw_pkg::OP_LOOP_END) || (op == psw_pkg::OP_BREAK) |=>
            ((psw_o & psw_pkg::CC_MASK) == ($past(psw_o) & psw_pkg::CC_MASK))
            && ((psw_o & ~psw_pkg::CC_MASK) == ($past(pop_data_i) & ~psw_pkg::CC_MASK
                & ~psw_pkg::RSVD_MASK))
    ) else $error("loop exit did not restore the mode bytes");

    chk_dyn_core_wins: assert property (
        @(posedge clk_i) disable iff (!rst_b_i)
        (core_dma_prio_select_i == 2'h0) && core_any
            && (psw_o[psw_pkg::CORE_PRIO_LSB +: 2] > dma_prio_field_i) |-> !grant_o[3]
    ) else $error("dma granted over higher dynamic core");

    chk_dyn_dma_wins: assert property (
        @(posedge clk_i) disable iff (!rst_b_i)
        (core_dma_prio_select_i == 2'h0) && dma_req_i
            && (psw_o[psw_pkg::CORE_PRIO_LSB +: 2] < dma_prio_field_i) |-> grant_o == 4'h8
    ) else $error("core granted over higher dynamic dma");

    // any request at all must win exactly one slot, so no bus cycle is lost
    chk_one_grant: assert property (
        @(posedge clk_i) disable iff (!rst_b_i)
        (req_all != 4'h0) |-> ($countones(grant_o) == 1)
    ) else $error("bus slot not granted to exactly one source");

endmodule : psw_top

// File: tb/tb.sv
// testbench: status word updates, stacking, rounding select and bus arbitration
`timescale 1ns/1ps
module tb;

    // ****************************************************************
    // signals and design instance
    // ****************************************************************
    logic              clk_i;
    logic              rst_b_i;
    psw_pkg::psw_req_t req_i;
    logic [23:0]       pop_data_i;
    logic [1:0]        core_dma_prio_select_i;
    logic [1:0]        dma_prio_field_i;
    logic [2:0]        core_req_i;
    logic              dma_req_i;
    logic [23:0]       psw_o;
    logic              round_select_o;
    logic              push_o;
    logic [23:0]       push_data_o;
    logic              pop_o;
    logic [3:0]        grant_o;
    int                n_errors;
    int                checked;
    logic [3:0]        rr_seq [5];

    psw_top u_psw_top (
        .clk_i                  (clk_i),
        .rst_b_i                (rst_b_i),
        .req_i                  (req_i),
        .pop_data_i             (pop_data_i),
        .core_dma_prio_select_i (core_dma_prio_select_i),
        .dma_prio_field_i       (dma_prio_field_i),
        .core_req_i             (core_req_i),
        .dma_req_i              (dma_req_i),
        .psw_o                  (psw_o),
        .round_select_o         (round_select_o),
        .push_o                 (push_o),
        .push_data_o            (push_data_o),
        .pop_o                  (pop_o),
        .grant_o                (grant_o)
    );

    // case equality so an unknown never counts as a match
    `define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin n_errors++; \
        $display("wrong value at %0t: got %h expected %h", $time, (got), (exp)); end end

    // ****************************************************************
    // clock, 50 MHz
    // ****************************************************************
    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end

    // ****************************************************************
    // tasks
    // ****************************************************************
    // one sequencer request, held for exactly one taken edge, then idle again
    task automatic run(input psw_pkg::psw_op_t o, input psw_pkg::psw_tgt_t t,
                       input logic [23:0] d, input logic [23:0] w, input logic [23:0] e,
                       input logic ep, input logic [23:0] epd);
        logic is_pop;
        is_pop = (o == psw_pkg::OP_LOOP_END) || (o == psw_pkg::OP_BREAK)
                 || (o == psw_pkg::OP_RTI);
        req_i      = '{op: o, tgt: t, data: d};
        pop_data_i = w;
        #1;
        `CHK(pop_o, is_pop)
        @(negedge clk_i);
        req_i      = '{op: psw_pkg::OP_NONE, tgt: psw_pkg::TGT_CC, data: 24'h000000};
        pop_data_i = ~w;
        `CHK(psw_o, e)
        `CHK(round_select_o, e[21])
        `CHK(push_o, ep)
        if (ep) begin
            `CHK(push_data_o, epd)
        end
        // one idle edge, so the next call never re-drives req_i in this time step
        @(negedge clk_i);
    endtask : run

    // one cycle of bus requests; the grant is combinational and looked at mid-cycle
    task automatic arb(input logic [1:0] sel, input logic [1:0] dp, input logic [2:0] cr,
                       input logic dr, input logic [3:0] exp);
        core_dma_prio_select_i = sel;
        dma_prio_field_i       = dp;
        core_req_i             = cr;
        dma_req_i              = dr;
        #1;
        `CHK(grant_o, exp)
        @(negedge clk_i);
    endtask : arb

    // single exit point for the whole run
    task automatic conclude();
        $display("errors %0d, comparisons %0d", n_errors, checked);
        if (n_errors == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : conclude

    // ****************************************************************
    // watchdog
    // ****************************************************************
    initial begin
        #200000;
        n_errors++;
        conclude();
    end

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        n_errors               = 0;
        checked                = 0;
        rst_b_i                = 1'b0;
        req_i                  = '{op: psw_pkg::OP_NONE, tgt: psw_pkg::TGT_CC, data: 24'h0};
        pop_data_i             = 24'h000000;
        core_dma_prio_select_i = 2'h0;
        dma_prio_field_i       = 2'h0;
        core_req_i             = 3'h0;
        dma_req_i              = 1'b0;
        rr_seq                 = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h1};
        repeat (5) @(negedge clk_i);
        rst_b_i = 1'b1;
        // reset image: priority 11, both masks set, all else clear
        `CHK(psw_o, 24'hc00300)
        `CHK(psw_o[15:8], 8'h03)
        `CHK(psw_o[7:0], 8'h00)
        `CHK(push_o, 1'b0)
        // equal priority: all four requesting rotate from program fetch
        core_dma_prio_select_i = psw_pkg::SEL_EQUAL;
        core_req_i             = 3'h7;
        dma_req_i              = 1'b1;
        for (int i = 0; i < 5; i++) begin
            #1;
            `CHK(grant_o, rr_seq[i])
            @(negedge clk_i);
        end
        // static modes: winner takes it, loser only when the winner is idle
        arb(psw_pkg::SEL_CORE_HI, 2'h0, 3'h1, 1'b1, 4'h1);
        arb(psw_pkg::SEL_CORE_HI, 2'h0, 3'h0, 1'b1, 4'h8);
        arb(psw_pkg::SEL_CORE_LO, 2'h3, 3'h1, 1'b1, 4'h8);
        arb(psw_pkg::SEL_CORE_LO, 2'h3, 3'h1, 1'b0, 4'h1);
        // dynamic: core field 3 beats channel priority 2
        arb(psw_pkg::SEL_DYNAMIC, 2'h2, 3'h1, 1'b1, 4'h1);
        // equal dynamic levels fall back to the rotation; pointer sits past program
        arb(psw_pkg::SEL_DYNAMIC, 2'h3, 3'h1, 1'b1, 4'h8);
        arb(psw_pkg::SEL_DYNAMIC, 2'h0, 3'h0, 1'b0, 4'h0);
        // condition byte sources
        run(psw_pkg::OP_ALU, psw_pkg::TGT_CC, 24'h0000ff, 24'h0, 24'hc003ff, 1'b0, 24'h0);
        run(psw_pkg::OP_PMOVE, psw_pkg::TGT_CC, 24'h0, 24'h0, 24'hc0033f, 1'b0, 24'h0);
        // full-word write: reserved bits stay clear, rounding bit follows
        run(psw_pkg::OP_MOVE, psw_pkg::TGT_PSW, 24'hffffff, 24'h0, 24'hfbefff, 1'b0, 24'h0);
        run(psw_pkg::OP_IMM_AND, psw_pkg::TGT_MODE, 24'h000f00, 24'h0, 24'hfb0fff, 1'b0, 24'h0);
        run(psw_pkg::OP_IMM_OR, psw_pkg::TGT_MODE, 24'h001000, 24'h0, 24'hfb0fff, 1'b0, 24'h0);
        run(psw_pkg::OP_IMM_AND, psw_pkg::TGT_CC, 24'h00000f, 24'h0, 24'hfb0f0f, 1'b0, 24'h0);
        run(psw_pkg::OP_IMM_OR, psw_pkg::TGT_CC, 24'h000030, 24'h0, 24'hfb0f3f, 1'b0, 24'h0);
        run(psw_pkg::OP_MOVE, psw_pkg::TGT_MODE, 24'h0, 24'h0, 24'hfb003f, 1'b0, 24'h0);
        run(psw_pkg::psw_op_t'(4'hf), psw_pkg::TGT_PSW, 24'h0, 24'h0, 24'hfb003f, 1'b0, 24'h0);
        run(psw_pkg::OP_CALL, psw_pkg::TGT_CC, 24'h0, 24'h0, 24'hfb003f, 1'b1, 24'hfb003f);
        run(psw_pkg::OP_MOVE, psw_pkg::TGT_PSW, 24'h0, 24'h0, 24'h000000, 1'b0, 24'h0);
        // loops stack the word before setting their flags
        run(psw_pkg::OP_LOOP, psw_pkg::TGT_CC, 24'h0, 24'h0, 24'h008000, 1'b1, 24'h000000);
        run(psw_pkg::OP_FOREVER, psw_pkg::TGT_PSW, 24'h0, 24'h0, 24'h018000, 1'b1, 24'h008000);
        run(psw_pkg::OP_TRAP, psw_pkg::TGT_CC, 24'h000300, 24'h0, 24'h018300, 1'b0, 24'h0);
        run(psw_pkg::OP_EXCEPT, psw_pkg::TGT_CC, 24'h000100, 24'h0, 24'h018100, 1'b1, 24'h018300);
        // restores from the stack: exits keep the condition byte, return takes all
        run(psw_pkg::OP_LOOP_END, psw_pkg::TGT_CC, 24'h0, 24'hffffff, 24'hfbef00, 1'b0, 24'h0);
        run(psw_pkg::OP_BREAK, psw_pkg::TGT_PSW, 24'h0, 24'h4000ff, 24'h400000, 1'b0, 24'h0);
        run(psw_pkg::OP_RTI, psw_pkg::TGT_CC, 24'h0, 24'h3c12a5, 24'h3802a5, 1'b0, 24'h0);
        // dynamic again with core field now 0: the channel wins
        arb(psw_pkg::SEL_DYNAMIC, 2'h1, 3'h1, 1'b1, 4'h8);
        arb(psw_pkg::SEL_DYNAMIC, 2'h1, 3'h1, 1'b0, 4'h1);
        arb(psw_pkg::SEL_DYNAMIC, 2'h0, 3'h0, 1'b0, 4'h0);
        // reset again in mid-run: reset image, cleared push word, pointer back on program
        rst_b_i = 1'b0;
        repeat (2) @(negedge clk_i);
        `CHK(psw_o, 24'hc00300)
        `CHK(round_select_o, 1'b0)
        `CHK(push_data_o, 24'h000000)
        rst_b_i = 1'b1;
        arb(psw_pkg::SEL_EQUAL, 2'h0, 3'h7, 1'b1, 4'h1);
        conclude();
    end

endmodule : tb
